// ### shared/touch_cmd_consts.svh
// Constants for the touch sensor command handler.
// Assumes a 50 MHz system clock; times are kept in ms and converted by tick.
`ifndef TOUCH_CMD_CONSTS_SVH
`define TOUCH_CMD_CONSTS_SVH
`define CLK_MHZ       50
`define TICK_US       1000
`define TICK_CYC      (`CLK_MHZ * `TICK_US)
`define CMD_WIN_MS    7'd110
`define BYTE_TO_MS    7'd110
`define TIME_STEP_MS  7'd100
`define SYNC_MAX_MS   7'd100
`define CAL_MAX_MS    12'd3000
`define CRC_CHECK_MS  10'd1000
`define SETUP_LEN     100
`define KEYS          48
`define CMD_LOAD      8'h01
`define CMD_LOWCAL    8'h02
`define CMD_CALALL    8'h03
`define CMD_RESET     8'h04
`define CMD_OVERVIEW  8'h06
`define ACK_LOAD      8'hfe
`define ACK_LOWCAL    8'hfd
`define ACK_CALALL    8'hfc
`define ACK_RESET     8'hfb
`define NAK_CRC       8'h00
`define CRC_POLY      16'h1021
`define CRC_INIT      16'hffff
`define REG_STATUS    4'h0
`define REG_COUNT     4'h4
`define REG_SETCRC    4'h8
`define REG_CTRL      4'hc
`define CTRL_RESET    2'h3
`define CTRL_STS_BIT  0
`define CTRL_SYNC_BIT 1
`endif

// ### shared/touch_cmd_pkg.sv
// Types shared by the touch sensor command handler.
// Assumes a classic Wishbone master on the register side.
package touch_cmd_pkg;
  typedef enum logic [7:0] {
    S_INIT  = 8'h01,
    S_IDLE  = 8'h02,
    S_LOAD  = 8'h04,
    S_CHECK = 8'h08,
    S_PROG  = 8'h10,
    S_CALW  = 8'h20,
    S_CAL   = 8'h40,
    S_RST   = 8'h80
  } state_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage

// ### verilog/touch_sensor_command_handler.sv
// Command interpreter for a 48-key touch controller: protected commands and overview.
// Assumes framed bytes from a serial receiver and a sensing engine on the same clock.
`timescale 1ns/1ps
`include "touch_cmd_consts.svh"
module touch_sensor_command_handler #(
  parameter int unsigned TICK_CYC  = `TICK_CYC,
  parameter int unsigned SETUP_LEN = `SETUP_LEN,
  parameter int unsigned KEYS      = `KEYS
)(
  // Clock, reset, enable
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // Register bus
  input  wire touch_cmd_pkg::wb_req_t wb_i,
  output touch_cmd_pkg::wb_rsp_t     wb_o,
  // Byte link
  input  wire logic                  rx_valid_i,
  input  wire logic [7:0]            rx_data_i,
  output logic                       ready_handshake_line_o,
  output logic                       tx_valid_o,
  output logic [7:0]                 tx_data_o,
  input  wire logic                  tx_ready_i,
  // Sensing engine
  output logic                       sensing_o,
  output logic                       cal_req_o,
  output logic                       cal_lowlevel_o,
  input  wire logic                  cal_done_i,
  input  wire logic                  cal_eval_i,
  input  wire logic [KEYS-1:0]       conv_fail_i,
  input  wire logic [KEYS-1:0]       low_signal_limit_i,
  input  wire logic [KEYS-1:0]       key_en_i,
  input  wire logic [KEYS-1:0]       key_touch_i,
  input  wire logic                  touch_change_i,
  input  wire logic                  safety_fault_i,
  input  wire logic                  scan_start_i,
  input  wire logic                  capture_fail_i,
  input  wire logic                  mains_sync_i,
  output logic                       status_pin_o,
  output logic [KEYS-1:0]            key_err_o,
  // Settings store
  output logic                       cfg_we_o,
  output logic [7:0]                 cfg_addr_o,
  output logic [7:0]                 cfg_data_o,
  output logic [7:0]                 cfg_rd_addr_o,
  input  wire logic [7:0]            cfg_rd_data_i,
  output logic                       nv_prog_o,
  output logic                       nv_bad_o,
  input  wire logic                  nv_done_i,
  input  wire logic                  nv_corrupt_i,
  output logic                       restore_o,
  output logic                       reset_req_o
);
  import touch_cmd_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam logic [7:0] LEN8 = 8'(SETUP_LEN);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  state_t        state_q;
  logic [TW-1:0] pre_q;
  logic          tick, sync_rise, sync_lvl_q, sync_err_q, prev_ok_q, hold_q, ld_ok_q;
  logic          q_one_q, q_ov_q, tx_busy, crc_store_q, touch_flag_q, scan_on_q, scan_vld_q;
  logic          crc_bad_q, ack_q, tfound, dbl, rx_take;
  logic [1:0]    ctrl_q, tcnt;
  logic [2:0]    sy_q, tx_len_q, tx_idx_q;
  logic [5:0]    tfirst;
  logic [6:0]    step_ms_q, sync_ms_q, gap_q;
  logic [7:0]    time_q, scan_q, fail_q, prev_q, idx_q, q_byte_q, dev_status;
  logic [7:0]    resp_q [0:6];
  logic [7:0]    ov [0:4];
  logic [9:0]    chk_ms_q;
  logic [11:0]   cal_ms_q;
  logic [15:0]   ld_crc_q, rx_crc_q, set_crc_q, scan_crc_q, ov_crc;
  logic [31:0]   rd_q;

  // Millisecond tick; the prescaler is a parameter so a bench can shorten it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
    end else if (ce_i) begin
      pre_q <= (pre_q == TW'(TICK_CYC - 1)) ? '0 : pre_q + TW'(1);
    end
  end
  assign tick = ce_i && (pre_q == TW'(TICK_CYC - 1));

  // Safety counters.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_ms_q <= '0;
      time_q    <= '0;
      scan_q    <= '0;
      fail_q    <= '0;
    end else if (ce_i) begin
      if (tick) begin
        if (step_ms_q == `TIME_STEP_MS - 7'd1) begin
          step_ms_q <= '0;
          time_q    <= time_q + 8'h01;
        end else begin
          step_ms_q <= step_ms_q + 7'd1;
        end
      end
      if (scan_start_i) scan_q <= scan_q + 8'h01;
      if (capture_fail_i) fail_q <= fail_q + 8'h01;
    end
  end

  // Mains sync pin: three stages, a change counts once the last two agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy_q       <= '0;
      sync_lvl_q <= 1'b0;
    end else if (ce_i) begin
      sy_q <= {sy_q[1:0], mains_sync_i};
      if (sy_q[1] == sy_q[2]) sync_lvl_q <= sy_q[2];
    end
  end
  assign sync_rise = (sy_q[1] == sy_q[2]) && sy_q[2] && !sync_lvl_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_ms_q  <= '0;
      sync_err_q <= 1'b0;
    end else if (ce_i) begin
      if (sync_rise) begin
        sync_ms_q  <= '0;
        sync_err_q <= 1'b0;
      end else if (tick && sync_ms_q != `SYNC_MAX_MS) begin
        sync_ms_q <= sync_ms_q + 7'd1;
      end else if (sync_ms_q == `SYNC_MAX_MS && ctrl_q[`CTRL_SYNC_BIT]) begin
        sync_err_q <= 1'b1;
      end
    end
  end

  // Touch summary: the count saturates, the lowest key number wins.
  always_comb begin
    tcnt   = '0;
    tfirst = '0;
    tfound = 1'b0;
    for (int k = 0; k < KEYS; k++) begin
      if (key_touch_i[k]) begin
        if (!tfound) tfirst = 6'(k);
        tfound = 1'b1;
        if (tcnt != 2'd3) tcnt = tcnt + 2'd1;
      end
    end
  end

  // Per-key calibration error flags; a failing evaluation beats the clear.
  for (genvar k = 0; k < KEYS; k++) begin : g_key
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        key_err_o[k] <= 1'b0;
      end else if (ce_i) begin
        if (cal_eval_i && (conv_fail_i[k] || low_signal_limit_i[k])) begin
          key_err_o[k] <= 1'b1;
        end else if (cal_req_o) begin
          key_err_o[k] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    dev_status    = 8'h00;
    dev_status[6] = |(key_err_o & key_en_i);
    dev_status[5] = safety_fault_i;
    dev_status[4] = crc_bad_q;
    dev_status[3] = sync_err_q;
    dev_status[2] = |(low_signal_limit_i & key_en_i);
    dev_status[1] = (state_q == S_CAL) || (state_q == S_CALW);
    ov[0] = dev_status;
    ov[1] = {tcnt, tfound ? tfirst : 6'd0};
    ov[2] = time_q;
    ov[3] = scan_q;
    ov[4] = fail_q;
    ov_crc = crc_byte(`CRC_INIT, `CMD_OVERVIEW);
    for (int i = 0; i < 5; i++) ov_crc = crc_byte(ov_crc, ov[i]);
  end

  // Reply sender; the overview is captured whole so its CRC matches its bytes.
  assign tx_busy    = (tx_idx_q != tx_len_q) || q_one_q || q_ov_q;
  assign tx_valid_o = tx_idx_q != tx_len_q;
  assign tx_data_o  = resp_q[tx_idx_q];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_len_q <= '0;
      tx_idx_q <= '0;
      for (int i = 0; i < 7; i++) resp_q[i] <= 8'h00;
    end else if (ce_i) begin
      if (q_ov_q) begin
        for (int i = 0; i < 5; i++) resp_q[i] <= ov[i];
        resp_q[5] <= ov_crc[7:0];
        resp_q[6] <= ov_crc[15:8];
        tx_len_q  <= 3'd7;
        tx_idx_q  <= '0;
      end else if (q_one_q) begin
        resp_q[0] <= q_byte_q;
        tx_len_q  <= 3'd1;
        tx_idx_q  <= '0;
      end else if (tx_valid_o && tx_ready_i) begin
        tx_idx_q <= tx_idx_q + 3'd1;
      end
    end
  end

  // Ready drops for a cycle after each byte and while a reply is pending.
  assign ready_handshake_line_o = ce_i && !hold_q && !tx_busy &&
                                  (state_q == S_IDLE || state_q == S_LOAD);
  assign rx_take = rx_valid_i && ready_handshake_line_o;
  assign dbl     = prev_ok_q && rx_data_i == prev_q && gap_q < `CMD_WIN_MS &&
                   rx_data_i >= `CMD_LOAD && rx_data_i <= `CMD_RESET;

  // Command and block-load sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_INIT;
      prev_q         <= 8'h00;
      prev_ok_q      <= 1'b0;
      hold_q         <= 1'b0;
      gap_q          <= '0;
      idx_q          <= '0;
      ld_crc_q       <= `CRC_INIT;
      rx_crc_q       <= '0;
      ld_ok_q        <= 1'b0;
      q_one_q        <= 1'b0;
      q_ov_q         <= 1'b0;
      q_byte_q       <= 8'h00;
      crc_store_q    <= 1'b0;
      sensing_o      <= 1'b0;
      cal_req_o      <= 1'b0;
      cal_lowlevel_o <= 1'b0;
      cal_ms_q       <= '0;
      cfg_we_o       <= 1'b0;
      cfg_addr_o     <= 8'h00;
      cfg_data_o     <= 8'h00;
      nv_prog_o      <= 1'b0;
      nv_bad_o       <= 1'b0;
      restore_o      <= 1'b0;
      reset_req_o    <= 1'b0;
    end else if (ce_i) begin
      hold_q      <= rx_take;
      q_one_q     <= 1'b0;
      q_ov_q      <= 1'b0;
      crc_store_q <= 1'b0;
      cal_req_o   <= 1'b0;
      cfg_we_o    <= 1'b0;
      nv_prog_o   <= 1'b0;
      restore_o   <= 1'b0;
      reset_req_o <= 1'b0;
      if (rx_take) gap_q <= '0;
      else if (tick && gap_q != 7'h7f) gap_q <= gap_q + 7'd1;
      case (state_q)
        S_INIT: begin
          // Strap is sampled after release, then a full calibration runs.
          restore_o      <= nv_corrupt_i;
          cal_req_o      <= 1'b1;
          cal_lowlevel_o <= 1'b0;
          cal_ms_q       <= '0;
          state_q        <= S_CAL;
        end
        S_IDLE: begin
          if (rx_take) begin
            prev_q    <= rx_data_i;
            prev_ok_q <= !dbl;
            if (dbl) begin
              q_one_q <= 1'b1;
              case (rx_data_i)
                `CMD_LOAD: begin
                  q_byte_q  <= `ACK_LOAD;
                  sensing_o <= 1'b0;
                  idx_q     <= '0;
                  ld_crc_q  <= `CRC_INIT;
                  state_q   <= S_LOAD;
                end
                `CMD_LOWCAL: begin
                  q_byte_q       <= `ACK_LOWCAL;
                  cal_lowlevel_o <= 1'b1;
                  state_q        <= S_CALW;
                end
                `CMD_CALALL: begin
                  q_byte_q       <= `ACK_CALALL;
                  cal_lowlevel_o <= 1'b0;
                  state_q        <= S_CALW;
                end
                default: begin
                  q_byte_q <= `ACK_RESET;
                  state_q  <= S_RST;
                end
              endcase
            end else if (rx_data_i == `CMD_OVERVIEW) begin
              q_ov_q <= 1'b1;
            end
          end
        end
        S_LOAD: begin
          if (rx_take) begin
            idx_q <= idx_q + 8'd1;
            if (idx_q < LEN8) begin
              cfg_we_o   <= 1'b1;
              cfg_addr_o <= idx_q;
              cfg_data_o <= rx_data_i;
              ld_crc_q   <= crc_byte(ld_crc_q, rx_data_i);
            end else if (idx_q == LEN8) begin
              rx_crc_q[7:0] <= rx_data_i;
            end else begin
              rx_crc_q[15:8] <= rx_data_i;
              state_q        <= S_CHECK;
            end
          end else if (gap_q >= `BYTE_TO_MS) begin
            sensing_o <= 1'b1;
            prev_ok_q <= 1'b0;
            state_q   <= S_IDLE;
          end
        end
        S_CHECK: begin
          ld_ok_q     <= rx_crc_q == ld_crc_q;
          q_one_q     <= rx_crc_q != ld_crc_q;
          q_byte_q    <= `NAK_CRC;
          nv_prog_o   <= 1'b1;
          nv_bad_o    <= rx_crc_q != ld_crc_q;
          crc_store_q <= 1'b1;
          state_q     <= S_PROG;
        end
        S_PROG: begin
          if (nv_done_i) begin
            q_one_q   <= ld_ok_q;
            q_byte_q  <= `ACK_LOAD;
            sensing_o <= 1'b1;
            prev_ok_q <= 1'b0;
            state_q   <= S_IDLE;
          end
        end
        S_CALW: begin
          if (!tx_busy) begin
            cal_req_o <= 1'b1;
            cal_ms_q  <= '0;
            state_q   <= S_CAL;
          end
        end
        S_CAL: begin
          sensing_o <= 1'b0;
          if (tick) cal_ms_q <= cal_ms_q + 12'd1;
          if (cal_done_i || cal_ms_q >= `CAL_MAX_MS) begin
            sensing_o <= 1'b1;
            prev_ok_q <= 1'b0;
            state_q   <= S_IDLE;
          end
        end
        S_RST: begin
          reset_req_o <= !tx_busy;
        end
        default: state_q <= S_INIT;
      endcase
    end
  end

  // Status pin: a touch event wins over the clear from an overview.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      touch_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (touch_change_i && ctrl_q[`CTRL_STS_BIT]) touch_flag_q <= 1'b1;
      else if (q_ov_q) touch_flag_q <= 1'b0;
    end
  end
  assign status_pin_o = touch_flag_q;

  // Periodic settings CRC sweep; read data arrives one cycle after the address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_ms_q      <= '0;
      scan_on_q     <= 1'b0;
      scan_vld_q    <= 1'b0;
      cfg_rd_addr_o <= 8'h00;
      scan_crc_q    <= `CRC_INIT;
      crc_bad_q     <= 1'b0;
    end else if (ce_i) begin
      if (!scan_on_q) begin
        if (tick) chk_ms_q <= chk_ms_q + 10'd1;
        if (chk_ms_q >= `CRC_CHECK_MS) begin
          chk_ms_q      <= '0;
          scan_on_q     <= 1'b1;
          scan_vld_q    <= 1'b0;
          cfg_rd_addr_o <= 8'h00;
          scan_crc_q    <= `CRC_INIT;
        end
      end else begin
        scan_vld_q <= cfg_rd_addr_o < LEN8;
        if (cfg_rd_addr_o < LEN8) cfg_rd_addr_o <= cfg_rd_addr_o + 8'd1;
        if (scan_vld_q) scan_crc_q <= crc_byte(scan_crc_q, cfg_rd_data_i);
        if (scan_vld_q && cfg_rd_addr_o == LEN8) begin
          scan_on_q <= 1'b0;
          crc_bad_q <= crc_byte(scan_crc_q, cfg_rd_data_i) != set_crc_q;
        end
      end
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q     <= 1'b0;
      rd_q      <= '0;
      set_crc_q <= `CRC_INIT;
      ctrl_q    <= `CTRL_RESET;
    end else if (ce_i) begin
      ack_q <= wb_i.cyc && wb_i.stb && !ack_q;
      if (crc_store_q) set_crc_q <= rx_crc_q;
      if (wb_i.cyc && wb_i.stb && !ack_q) begin
        rd_q <= '0;
        if (wb_i.adr[31:4] == 28'h0) begin
          case (wb_i.adr[3:0])
            `REG_STATUS: rd_q <= {14'h0, sensing_o, state_q == S_LOAD, ov[1], dev_status};
            `REG_COUNT:  rd_q <= {8'h00, fail_q, scan_q, time_q};
            `REG_SETCRC: rd_q <= {16'h0000, set_crc_q};
            `REG_CTRL:   rd_q <= {30'h0, ctrl_q};
            default:     rd_q <= '0;
          endcase
          if (wb_i.we && wb_i.adr[3:0] == `REG_SETCRC && !crc_store_q) begin
            if (wb_i.sel[0]) set_crc_q[7:0] <= wb_i.dat[7:0];
            if (wb_i.sel[1]) set_crc_q[15:8] <= wb_i.dat[15:8];
          end
          if (wb_i.we && wb_i.adr[3:0] == `REG_CTRL && wb_i.sel[0]) begin
            ctrl_q <= wb_i.dat[1:0];
          end
        end
      end
    end
  end
  assign wb_o = '{ack: ack_q, dat: rd_q};

endmodule // touch_sensor_command_handler

// ### dv/touch_cmd_sva.sv
// Checker for the touch command handler, bound to the ports of its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module touch_cmd_sva #(
  parameter int unsigned TICK_CYC  = 50000,
  parameter int unsigned SETUP_LEN = 100,
  parameter int unsigned KEYS      = 48
)(
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // Register bus
  input wire touch_cmd_pkg::wb_req_t wb_i,
  input wire touch_cmd_pkg::wb_rsp_t wb_o,
  // Byte link
  input wire logic                   rx_valid_i,
  input wire logic                   ready_handshake_line_o,
  // Sensing engine and settings store
  input wire logic                   cal_req_o,
  input wire logic                   cal_eval_i,
  input wire logic [KEYS-1:0]        conv_fail_i,
  input wire logic [KEYS-1:0]        low_signal_limit_i,
  input wire logic [KEYS-1:0]        key_err_o,
  input wire logic                   touch_change_i,
  input wire logic                   status_pin_o,
  input wire logic                   sensing_o,
  input wire logic                   cfg_we_o,
  input wire logic                   nv_prog_o,
  input wire logic                   nv_done_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_wb_ack; wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus request not answered after one wait");
  property p_wb_pulse; wb_o.ack |=> !wb_o.ack; endproperty
  a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack longer than one cycle");
  property p_rdy_drop; rx_valid_i && ready_handshake_line_o |=> !ready_handshake_line_o; endproperty
  a_rdy_drop: assert property (p_rdy_drop) else $error("ready not released after a byte");
  property p_boot_cal; $fell(rst_i) |=> cal_req_o; endproperty
  a_boot_cal: assert property (p_boot_cal) else $error("no calibration after reset");
  property p_cal_busy; cal_req_o |-> !ready_handshake_line_o [*3]; endproperty
  a_cal_busy: assert property (p_cal_busy) else $error("link open while calibrating");
  property p_load_halt; cfg_we_o || nv_prog_o |-> !sensing_o; endproperty
  a_load_halt: assert property (p_load_halt) else $error("sensing during block load");
  property p_no_recal; nv_done_i |-> !cal_req_o [*4]; endproperty
  a_no_recal: assert property (p_no_recal) else $error("recalibration after block load");
  property p_key_err;
    cal_eval_i |=> (key_err_o & $past(conv_fail_i | low_signal_limit_i))
                   == $past(conv_fail_i | low_signal_limit_i);
  endproperty
  a_key_err: assert property (p_key_err) else $error("key error flag not set");
  property p_pin_cause; $rose(status_pin_o) |-> $past(touch_change_i); endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("status pin rose without touch");

  c_load: cover property (nv_done_i ##[1:5] sensing_o);
  c_eval: cover property (cal_eval_i && conv_fail_i != '0);
  c_pin: cover property ($rose(status_pin_o) ##[1:900] $fell(status_pin_o));
endmodule // touch_cmd_sva

bind touch_sensor_command_handler touch_cmd_sva #(.TICK_CYC(TICK_CYC), .SETUP_LEN(SETUP_LEN),
  .KEYS(KEYS)) u_sva (.clk_i, .rst_i, .wb_i, .wb_o, .rx_valid_i, .ready_handshake_line_o,
  .cal_req_o, .cal_eval_i, .conv_fail_i, .low_signal_limit_i, .key_err_o, .touch_change_i,
  .status_pin_o, .sensing_o, .cfg_we_o, .nv_prog_o, .nv_done_i);

// ### dv/host_link_model.sv
// Host side of the byte link: offers paced bytes and takes reply bytes.
// Assumes the handler's ready line and reply handshake on the same clock.
`timescale 1ns/1ps
module host_link_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Byte link
  input  wire logic       ready_i,
  input  wire logic       slow_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            tx_ready_o
);
  logic [1:0] div_q;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
  end
  // A slow host takes a reply byte one cycle in four.
  always @(posedge clk_i) begin
    div_q      <= rst_i ? 2'd0 : div_q + 2'd1;
    tx_ready_o <= !slow_i || div_q == 2'd0;
  end
  // The gap before each byte is a count of clock cycles, so pairs and block bytes stay well inside the 110 ms windows.
  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o  <= b;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~b;
  endtask
endmodule // host_link_model

// ### dv/tb.sv
// Self-checking bench for the touch command handler with a host model on the link.
// Assumes the checker binds itself; the bench plays sensing engine and settings store.
`timescale 1ns/1ps
module tb;
  import touch_cmd_pkg::*;
  localparam int SL = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, slow = 1'b0, rest_seen = 1'b0;
  logic rx_valid_i, tx_ready_i, ready_handshake_line_o, tx_valid_o, sensing_o, cal_req_o;
  logic cal_lowlevel_o, status_pin_o, cfg_we_o, nv_prog_o, nv_bad_o, restore_o, reset_req_o;
  logic cal_done_i = 1'b0, cal_eval_i = 1'b0, touch_change_i = 1'b0, scan_start_i = 1'b0;
  logic capture_fail_i = 1'b0, mains_sync_i = 1'b0, nv_done_i = 1'b0, nv_corrupt_i = 1'b0;
  logic safety_fault_i = 1'b1;
  logic [7:0] rx_data_i, tx_data_o, cfg_addr_o, cfg_data_o, cfg_rd_addr_o, cfg_rd_data_i = 8'h00;
  logic [47:0] conv_fail_i = 48'h8, low_signal_limit_i = 48'h80, key_en_i = '1;
  logic [47:0] key_touch_i = 48'h100200, key_err_o;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] txq [$];
  logic [31:0] wbq [$], cyc = '0;
  logic [4:0] cal_n = '0;
  integer seed = 32'h8a3c4184;
  int err_count = 0, checks = 0;
  wb_req_t wb_i = '0;
  wb_rsp_t wb_o;

  touch_sensor_command_handler #(.TICK_CYC(50), .SETUP_LEN(SL)) uut (.clk_i, .rst_i, .ce_i,
    .wb_i, .wb_o, .rx_valid_i, .rx_data_i, .ready_handshake_line_o, .tx_valid_o, .tx_data_o,
    .tx_ready_i, .sensing_o, .cal_req_o, .cal_lowlevel_o, .cal_done_i, .cal_eval_i, .conv_fail_i,
    .low_signal_limit_i, .key_en_i, .key_touch_i, .touch_change_i, .safety_fault_i, .scan_start_i,
    .capture_fail_i, .mains_sync_i, .status_pin_o, .key_err_o, .cfg_we_o, .cfg_addr_o, .cfg_data_o,
    .cfg_rd_addr_o, .cfg_rd_data_i, .nv_prog_o, .nv_bad_o, .nv_done_i, .nv_corrupt_i, .restore_o,
    .reset_req_o);
  host_link_model host (.clk_i, .rst_i, .ready_i(ready_handshake_line_o), .slow_i(slow),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));

  always #10 clk_i = ~clk_i;

  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic check(input string what, input logic [47:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [31:0] a, d, e);
    wb_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
    if (!we) wbq.push_back(e);
    do @(posedge clk_i); while (wb_o.ack !== 1'b1);
    wb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic drain();
    while (txq.size() != 0) @(posedge clk_i);
  endtask
  task automatic cmd2(input logic [7:0] code, ack);
    txq.push_back(ack);
    host.send(code, 6);
    host.send(code, 6);
    drain();
  endtask
  task automatic load(input logic bad, output logic [15:0] c);
    logic [7:0] b;
    c = 16'hffff;
    cmd2(8'h01, 8'hfe);
    for (int i = 0; i < SL; i++) begin
      b = 8'($random(seed));
      c = crc16(c, b);
      host.send(b, 6);
    end
    c = c ^ {15'h0, bad};
    txq.push_back(bad ? 8'h00 : 8'hfe);
    host.send(c[7:0], 6);
    host.send(c[15:8], 6);
    drain();
    repeat (4) @(posedge clk_i);
    check("sensing", sensing_o, 1'b1);
    wb(1'b0, 32'h8, '0, {16'h0, c});
  endtask

  // The engine is quick, but its calibration still spans twenty cycles.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    mains_sync_i <= cyc[9];
    cal_n <= cal_req_o ? 5'd20 : cal_n - 5'(cal_n != 0);
    cal_eval_i <= cal_n == 5'd2;
    cal_done_i <= cal_n == 5'd1;
    nv_done_i <= nv_prog_o;
    if (cfg_we_o) mem[cfg_addr_o] <= cfg_data_o;
    cfg_rd_data_i <= mem[cfg_rd_addr_o];
    rest_seen <= rest_seen | restore_o;
    if (cyc == 32'd30000) begin
      err_count++;
      end_sim();
    end
  end
  always @(posedge clk_i) begin
    if (wb_o.ack === 1'b1 && wb_i.we === 1'b0)
      check("bus read", wb_o.dat, wbq.pop_front());
    if (rst_i === 1'b0 && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      check("reply", tx_data_o, txq.pop_front());
  end

  initial begin
    logic [15:0] c, g;
    logic [39:0] ov;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 32'hc, '0, 32'h3);
    wb(1'b1, 32'h8, 32'h1234, '0);
    wb(1'b1, 32'h40, 32'h55, '0);
    wb(1'b0, 32'h40, '0, '0);
    wb(1'b0, 32'h8, '0, 32'h1234);
    repeat (30) @(posedge clk_i);
    check("key errors", key_err_o, 48'h88);
    for (int i = 0; i < 3; i++) begin
      {scan_start_i, capture_fail_i, touch_change_i} <= {1'b1, i < 2, i == 0};
      @(posedge clk_i);
      {scan_start_i, capture_fail_i, touch_change_i} <= 3'b000;
      @(posedge clk_i);
    end
    check("status pin", status_pin_o, 1'b1);
    ov = 40'h64_89_00_03_02;
    c = crc16(16'hffff, 8'h06);
    for (int i = 4; i >= 0; i--) begin
      txq.push_back(ov[i*8 +: 8]);
      c = crc16(c, ov[i*8 +: 8]);
    end
    txq.push_back(c[7:0]);
    txq.push_back(c[15:8]);
    host.send(8'h06, 6);
    drain();
    check("status pin", status_pin_o, 1'b0);
    slow <= 1'b1;
    host.send(8'h01, 6);
    repeat (5600) @(posedge clk_i);
    load(1'b0, g);
    load(1'b1, c);
    nv_corrupt_i <= 1'b1;
    check("bad flag", nv_bad_o, 1'b1);
    cmd2(8'h01, 8'hfe);
    host.send(8'h5a, 6);
    repeat (5600) @(posedge clk_i);
    check("sensing", sensing_o, 1'b1);
    cmd2(8'h02, 8'hfd);
    wb(1'b0, 32'h0, '0, 32'h0002_8966);
    repeat (40) @(posedge clk_i);
    check("low cal", cal_lowlevel_o, 1'b1);
    wb(1'b0, 32'h8, '0, {16'h0, c});
    cmd2(8'h03, 8'hfc);
    repeat (40) @(posedge clk_i);
    check("low cal", cal_lowlevel_o, 1'b0);
    cmd2(8'h04, 8'hfb);
    while (reset_req_o !== 1'b1) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    check("restore", rest_seen, 1'b1);
    check("sensing", sensing_o, 1'b1);
    end_sim();
  end
endmodule // tb
